// ### logic/nci_pkg.sv
// Purpose: Constants for the NAND command/address host controller
// Assumes: 8-bit multiplexed flash bus, 20 MHz core clock
// Notes: Functional notes below
package nci_pkg;
  localparam logic [7:0] CMD_SEQ_IN   = 8'h80;
  localparam logic [7:0] CMD_READ_A   = 8'h00;
  localparam logic [7:0] CMD_READ_B   = 8'h01;
  localparam logic [7:0] CMD_READ_SP  = 8'h50;
  localparam logic [7:0] CMD_READ_ID  = 8'h90;
  localparam logic [7:0] CMD_RESET    = 8'hFF;
  localparam logic [7:0] CMD_PROG     = 8'h10;
  localparam logic [7:0] CMD_ERASE    = 8'h60;
  localparam logic [7:0] CMD_ERASE_GO = 8'hD0;
  localparam logic [7:0] CMD_STATUS   = 8'h70;
  localparam int         ADDR_W       = 23;
  localparam int         PAGE_BYTES   = 528;
  localparam logic [9:0] PAGE_LAST    = 10'h20F;
  localparam logic [1:0] PH_SETUP     = 2'h0;
  localparam logic [1:0] PH_LOW       = 2'h1;
  localparam logic [1:0] PH_HIGH      = 2'h2;
  localparam logic [1:0] PH_LAST      = 2'h3;
  // Strobe phases are one 50 ns clock each: a 200 ns cycle per byte
  typedef enum logic [3:0] {
    NCI_IDLE   = 4'h0,
    NCI_CMD    = 4'h1,
    NCI_COL    = 4'h2,
    NCI_ROWL   = 4'h3,
    NCI_ROWH   = 4'h4,
    NCI_CONF   = 4'h5,
    NCI_WAIT   = 4'h6,
    NCI_WDATA  = 4'h7,
    NCI_PCMD   = 4'h8,
    NCI_RDATA  = 4'h9,
    NCI_DONE   = 4'hA
  } nci_state_t;
  typedef enum logic [2:0] {
    OP_READ    = 3'h0,
    OP_PROG    = 3'h1,
    OP_ERASE   = 3'h2,
    OP_STATUS  = 3'h3,
    OP_RESET   = 3'h4,
    OP_READ_ID = 3'h5
  } nci_op_t;
endpackage : nci_pkg

// ### logic/nci_host.sv
// Purpose: Host controller driving the NAND flash pins
// Assumes: Flash ready/busy is open drain, pulled up outside
// Notes: Two-entry buffer holds read bytes so a stall loses nothing
`default_nettype none
module nci_buf2 (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       in_valid,
  output logic            in_ready,
  input  wire logic [7:0] in_data,
  output logic            out_valid,
  input  wire logic       out_ready,
  output logic [7:0]      out_data
);
  logic [7:0] mem_r [2];
  logic [1:0] cnt_r;
  logic       wp_r;
  logic       rp_r;
  wire        push = in_valid && in_ready;
  wire        pop  = out_valid && out_ready;
  assign in_ready  = (cnt_r != 2'd2);
  assign out_valid = (cnt_r != 2'd0);
  assign out_data  = mem_r[rp_r];
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 2'd0;
      wp_r  <= 1'b0;
      rp_r  <= 1'b0;
      mem_r[0] <= 8'h00;
      mem_r[1] <= 8'h00;
    end else begin
      if (push) begin
        mem_r[wp_r] <= in_data;
        wp_r <= ~wp_r;
      end
      if (pop) rp_r <= ~rp_r;
      cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule : nci_buf2

module nci_host (
  input  wire logic              CORE_CLK,
  input  wire logic              RST_N,
  input  wire logic              REQ_VALID,
  output logic                   REQ_READY,
  input  wire nci_pkg::nci_op_t  REQ_OP,
  input  wire logic [22:0]       REQ_ADDR,
  input  wire logic [9:0]        REQ_LEN,
  input  wire logic              REQ_SPARE,
  input  wire logic              WR_VALID,
  output logic                   WR_READY,
  input  wire logic [7:0]        WR_DATA,
  output logic                   RD_VALID,
  input  wire logic              RD_READY,
  output logic [7:0]             RD_DATA,
  output logic                   DONE,
  output logic                   BUSY,
  output logic                   CLE,
  output logic                   ALE,
  output logic                   CHIP_SEL_N,
  output logic                   WRITE_STROBE_N,
  output logic                   OUTPUT_STROBE_N,
  output logic                   SPARE_AREA_GATE_N,
  output logic                   WRITE_PROTECT_N,
  input  wire logic [7:0]        IO_IN,
  output logic [7:0]             IO_OUT,
  output logic                   IO_OE_N,
  input  wire logic              READY_BUSY_N
);
  import nci_pkg::*;
  nci_state_t  st_r, st_nxt;
  nci_op_t     op_r;
  logic [22:0] addr_r;
  logic [9:0]  left_r;
  logic        spare_r;
  logic        pre_r;
  logic [1:0]  ph_r;
  logic [7:0]  io_r;
  logic        rb_m_r, rb_s_r;
  logic [7:0]  d_m_r, d_s_r;
  logic        cle_r, ale_r, we_n_r, re_n_r, oe_n_r, cs_n_r;
  logic        done_r;
  logic        b_in_ready;
  wire         ph_end  = (ph_r == PH_LAST);
  wire         we_phase = (ph_r == PH_LOW) || (ph_r == PH_HIGH);
  wire         is_write = (st_r == NCI_CMD) || (st_r == NCI_COL) || (st_r == NCI_ROWL) ||
                          (st_r == NCI_ROWH) || (st_r == NCI_CONF) || (st_r == NCI_PCMD) ||
                          (st_r == NCI_WDATA);
  wire         wr_stall = (st_r == NCI_WDATA) && (ph_r == PH_SETUP) && !WR_VALID;
  wire         rd_stall = (st_r == NCI_RDATA) && (ph_r == PH_SETUP) && !b_in_ready;
  wire         capture  = (st_r == NCI_RDATA) && (ph_r == PH_LAST);
  wire         last_byte = (left_r == 10'd1);
  wire         is_read_op = (op_r == OP_READ) || (op_r == OP_READ_ID) || (op_r == OP_STATUS);
  // 01h picks second half, 50h only used with spare gate low
  wire [7:0]   rd_cmd   = spare_r ? CMD_READ_SP : (addr_r[8] ? CMD_READ_B : CMD_READ_A);
  // second-half program sends the 01h pointer byte ahead of 80h
  wire [7:0]   cmd_byte = (op_r == OP_PROG)    ? (pre_r ? CMD_READ_B : CMD_SEQ_IN) :
                          (op_r == OP_ERASE)   ? CMD_ERASE :
                          (op_r == OP_STATUS)  ? CMD_STATUS :
                          (op_r == OP_RESET)   ? CMD_RESET :
                          (op_r == OP_READ_ID) ? CMD_READ_ID : rd_cmd;
  assign REQ_READY  = (st_r == NCI_IDLE);
  assign WR_READY   = (st_r == NCI_WDATA) && (ph_r == PH_SETUP);
  assign DONE       = done_r;
  assign BUSY       = (st_r != NCI_IDLE);
  assign CLE        = cle_r;
  assign ALE        = ale_r;
  assign CHIP_SEL_N = cs_n_r;
  assign WRITE_STROBE_N  = we_n_r;
  assign OUTPUT_STROBE_N = re_n_r;
  assign SPARE_AREA_GATE_N = ~spare_r;
  assign WRITE_PROTECT_N = 1'b1;
  assign IO_OUT  = io_r;
  assign IO_OE_N = oe_n_r;
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      NCI_IDLE:  if (REQ_VALID) st_nxt = NCI_CMD;
      NCI_CMD:   if (ph_end) begin
        if (pre_r) st_nxt = NCI_CMD;
        else if (op_r == OP_ERASE) st_nxt = NCI_ROWL;
        else if (op_r == OP_READ_ID) st_nxt = NCI_COL;
        else if (op_r == OP_STATUS) st_nxt = NCI_RDATA;
        else if (op_r == OP_RESET) st_nxt = NCI_WAIT;
        else st_nxt = NCI_COL;
      end
      NCI_COL:   if (ph_end) st_nxt = (op_r == OP_READ_ID) ? NCI_RDATA : NCI_ROWL;
      NCI_ROWL:  if (ph_end) st_nxt = NCI_ROWH;
      NCI_ROWH:  if (ph_end) begin
        if (op_r == OP_ERASE) st_nxt = NCI_CONF;
        else if (op_r == OP_PROG) st_nxt = NCI_WDATA;
        else st_nxt = NCI_WAIT;
      end
      NCI_CONF:  if (ph_end) st_nxt = NCI_WAIT;
      NCI_WDATA: if (ph_end && last_byte) st_nxt = NCI_PCMD;
      // One program pass per request; the caller counts partial passes per page
      NCI_PCMD:  if (ph_end) st_nxt = NCI_WAIT;
      // wait two clocks, then for busy high, before the next phase
      NCI_WAIT:  if (ph_end) st_nxt = (op_r == OP_READ) ? NCI_RDATA : NCI_DONE;
      NCI_RDATA: if (ph_end && last_byte) st_nxt = NCI_DONE;
      NCI_DONE:  st_nxt = NCI_IDLE;
      default:   st_nxt = NCI_IDLE;
    endcase
  end
  // Bus byte for the current write phase
  wire [7:0] out_byte = (st_r == NCI_CMD)   ? cmd_byte :
                        (st_r == NCI_COL)   ? addr_r[7:0] :
                        (st_r == NCI_ROWL)  ? addr_r[16:9] :
                        (st_r == NCI_ROWH)  ? {2'b00, addr_r[22:17]} :
                        (st_r == NCI_CONF)  ? CMD_ERASE_GO :
                        (st_r == NCI_PCMD)  ? CMD_PROG : WR_DATA;
  // Wait phase: two clocks let busy reach the synchroniser, then hold until ready; a short op may miss busy
  wire wait_go = (st_r == NCI_WAIT) &&
                 ((ph_r == PH_SETUP) || (ph_r == PH_LOW) || ((ph_r == PH_HIGH) && rb_s_r) || ph_end);
  wire ph_go = (st_r != NCI_IDLE) && (st_r != NCI_DONE) && !wr_stall && !rd_stall &&
               ((st_r != NCI_WAIT) || wait_go);
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      rb_m_r <= 1'b1;
      rb_s_r <= 1'b1;
      d_m_r  <= 8'h00;
      d_s_r  <= 8'h00;
    end else begin
      rb_m_r <= READY_BUSY_N;
      rb_s_r <= rb_m_r;
      d_m_r  <= IO_IN;
      d_s_r  <= d_m_r;
    end
  end
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      st_r    <= NCI_IDLE;
      op_r    <= OP_READ;
      addr_r  <= 23'h00_0000;
      left_r  <= 10'h000;
      spare_r <= 1'b0;
      pre_r   <= 1'b0;
      ph_r    <= PH_SETUP;
      done_r  <= 1'b0;
    end else begin
      st_r   <= st_nxt;
      done_r <= (st_r == NCI_DONE);
      if (st_r == NCI_IDLE && REQ_VALID) begin
        op_r    <= REQ_OP;
        addr_r  <= REQ_ADDR;
        left_r  <= (REQ_OP == OP_STATUS || REQ_OP == OP_READ_ID) ? 10'h001 : REQ_LEN;
        spare_r <= REQ_SPARE && (REQ_OP == OP_READ);
        pre_r   <= (REQ_OP == OP_PROG) && REQ_ADDR[8];
        ph_r    <= PH_SETUP;
      end else if (ph_go) begin
        ph_r <= ph_r + 2'd1;
        if (ph_end && (st_r == NCI_CMD)) pre_r <= 1'b0;
        // one byte per write or read strobe, column counted by the device
        if (ph_end && ((st_r == NCI_WDATA) || (st_r == NCI_RDATA)))
          left_r <= left_r - 10'd1;
      end
    end
  end
  // Pin drive: one clock setup, two clocks strobe low, one clock hold
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      cle_r  <= 1'b0;
      ale_r  <= 1'b0;
      cs_n_r <= 1'b1;
      we_n_r <= 1'b1;
      re_n_r <= 1'b1;
      oe_n_r <= 1'b1;
      io_r   <= 8'h00;
    end else begin
      cs_n_r <= !((st_nxt != NCI_IDLE) && (st_nxt != NCI_DONE));
      cle_r  <= (st_r == NCI_CMD) || (st_r == NCI_CONF) || (st_r == NCI_PCMD);
      ale_r  <= (st_r == NCI_COL) || (st_r == NCI_ROWL) || (st_r == NCI_ROWH);
      we_n_r <= !(is_write && we_phase && !wr_stall);
      // Read strobe leads by a clock so the byte clears the two-stage sync before capture
      re_n_r <= !((st_r == NCI_RDATA) && (((ph_r == PH_SETUP) && !rd_stall) || (ph_r == PH_LOW)));
      oe_n_r <= !is_write;
      if (is_write && (ph_r == PH_SETUP)) io_r <= out_byte;
    end
  end
  nci_buf2 u_buf (
    .clk       (CORE_CLK),
    .rst_n     (RST_N),
    .in_valid  (capture),
    .in_ready  (b_in_ready),
    .in_data   (d_s_r),
    .out_valid (RD_VALID),
    .out_ready (RD_READY),
    .out_data  (RD_DATA)
  );
endmodule : nci_host
`default_nettype wire

// ### dv/nci_host_chk.sv
// Purpose: Pin protocol checks for the NAND host
// Assumes: Four core clocks per flash byte
// Notes: Sees only the top module ports
`default_nettype none
module nci_host_chk
  import nci_pkg::*;
(
  input wire logic       CORE_CLK,
  input wire logic       RST_N,
  input wire logic       DONE,
  input wire logic       CLE,
  input wire logic       ALE,
  input wire logic       CHIP_SEL_N,
  input wire logic       WRITE_STROBE_N,
  input wire logic       OUTPUT_STROBE_N,
  input wire logic       SPARE_AREA_GATE_N,
  input wire logic [7:0] IO_OUT,
  input wire logic       IO_OE_N,
  input wire logic       READY_BUSY_N
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);
  property p_sel_excl; !(CLE && ALE); endproperty
  a_sel_excl: assert property (p_sel_excl) else $error("CLE and ALE high together");
  property p_we_sel; !WRITE_STROBE_N |-> !CHIP_SEL_N && !IO_OE_N; endproperty
  a_we_sel: assert property (p_we_sel) else $error("Write strobe without select or drive");
  property p_we_pulse; $fell(WRITE_STROBE_N) |=> !WRITE_STROBE_N ##1 WRITE_STROBE_N; endproperty
  a_we_pulse: assert property (p_we_pulse) else $error("Write strobe not two clocks low");
  property p_we_hold; !WRITE_STROBE_N |-> $stable(CLE) && $stable(ALE) && $stable(IO_OUT); endproperty
  a_we_hold: assert property (p_we_hold) else $error("Latch selects or byte moved under strobe");
  property p_re_sel; !OUTPUT_STROBE_N |-> !CHIP_SEL_N && IO_OE_N && WRITE_STROBE_N; endproperty
  a_re_sel: assert property (p_re_sel) else $error("Read strobe while driving or deselected");
  property p_re_pulse; $fell(OUTPUT_STROBE_N) |=> !OUTPUT_STROBE_N ##1 OUTPUT_STROBE_N; endproperty
  a_re_pulse: assert property (p_re_pulse) else $error("Read strobe not two clocks low");
  property p_spare; CLE && !WRITE_STROBE_N && IO_OUT == CMD_READ_SP |-> !SPARE_AREA_GATE_N; endproperty
  a_spare: assert property (p_spare) else $error("Spare read command with gate high");
  property p_done_rdy; DONE |-> $past(READY_BUSY_N, 2); endproperty
  a_done_rdy: assert property (p_done_rdy) else $error("Done while flash busy");
  c_erase: cover property (CLE && !WRITE_STROBE_N && IO_OUT == CMD_ERASE_GO);
  c_read: cover property ($fell(OUTPUT_STROBE_N));
  c_done: cover property (DONE);
endmodule : nci_host_chk
bind nci_host nci_host_chk u_chk (.*);
`default_nettype wire

// ### dv/nci_flash_model.sv
// Purpose: Behavioural flash device on the host pins
// Assumes: Erased bytes read as FF
// Notes: Busy time is short so the run stays brief
`default_nettype none
module nci_flash_model import nci_pkg::*; #(
  parameter logic [7:0] ID_VAL   = 8'h5A, // Arbitrary identity value
  parameter logic [7:0] STAT_VAL = 8'hC0,
  parameter int         BUSY_NS  = 700
) (
  input wire logic       CLE,
  input wire logic       ALE,
  input wire logic       CHIP_SEL_N,
  input wire logic       WRITE_STROBE_N,
  input wire logic       OUTPUT_STROBE_N,
  input wire logic       SPARE_AREA_GATE_N,
  input wire logic [7:0] IO_OUT,
  input wire logic       IO_OE_N,
  output logic [7:0]     IO_IN,
  output logic           READY_BUSY_N
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [int];
  logic [7:0] pg [0:527] = '{default: 8'hFF};
  logic [7:0] cmd = 8'hFF, dout = 8'h00;
  logic       half = 1'b0, busy = 1'b0;
  int         col = 0, row = 0, acnt = 0;
  assign READY_BUSY_N = !busy;
  // Undriven bus shows the inverse, so a stale sample cannot pass
  assign IO_IN = !IO_OE_N ? IO_OUT : (!CHIP_SEL_N ? dout : ~dout);
  task automatic hold_busy;
    busy = 1'b1;
    fork
      #(BUSY_NS) busy = 1'b0;
    join_none
  endtask : hold_busy
  always @(posedge WRITE_STROBE_N) begin
    if (!CHIP_SEL_N && CLE && (!busy || IO_OUT == CMD_RESET || IO_OUT == CMD_STATUS)) begin
      if (IO_OUT == CMD_ERASE_GO && cmd == CMD_ERASE) begin
        for (int i = (row & ~15) * 528; i < ((row | 15) + 1) * 528; i++) mem.delete(i);
        hold_busy();
      end
      if (IO_OUT == CMD_PROG) begin
        for (int i = 0; i < 528; i++) if (pg[i] != 8'hFF) mem[row * 528 + i] = pg[i];
        hold_busy();
      end
      if (IO_OUT == CMD_SEQ_IN) pg = '{default: 8'hFF};
      if (IO_OUT == CMD_READ_A || IO_OUT == CMD_READ_B) half = IO_OUT[0];
      cmd = IO_OUT;
      acnt = 0;
    end else if (!CHIP_SEL_N && ALE) begin
      case (acnt + int'(cmd == CMD_ERASE))
        0: col = (cmd == CMD_READ_SP) ? 512 + IO_OUT[3:0] : {half, IO_OUT};
        1: row[7:0] = IO_OUT;
        default: row[13:8] = IO_OUT[5:0];
      endcase
      half = 1'b0;
      acnt++;
      if (acnt == 3 && cmd inside {CMD_READ_A, CMD_READ_B, CMD_READ_SP}) begin
        foreach (pg[i]) pg[i] = mem.exists(row * 528 + i) ? mem[row * 528 + i] : 8'hFF;
        hold_busy();
      end
    end else if (!CHIP_SEL_N && !busy && col < 528) begin
      pg[col] = IO_OUT;
      col++;
    end
  end
  always @(negedge OUTPUT_STROBE_N) begin
    if (!CHIP_SEL_N) begin
      if (cmd == CMD_STATUS) dout = STAT_VAL;
      else if (cmd == CMD_READ_ID) dout = ID_VAL;
      else if (cmd == CMD_READ_SP && SPARE_AREA_GATE_N) dout = 8'h00;
      else dout = pg[col % 528];
      col++;
    end
  end
endmodule : nci_flash_model
`default_nettype wire

// ### dv/nci_host_tb.sv
// Purpose: Self-checking bench for the NAND host controller
// Assumes: Behavioural flash model on the pins
// Notes: Read stream stalls 32 clocks at a time to fill the buffer
`default_nettype none
module nci_host_tb import nci_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic        CORE_CLK = 0, RST_N = 0, REQ_VALID = 0, REQ_SPARE = 0, WR_VALID = 0, RD_READY = 0;
  nci_op_t     REQ_OP = OP_READ;
  logic [22:0] REQ_ADDR = '0;
  logic [9:0]  REQ_LEN = 10'h001;
  logic [7:0]  WR_DATA = '0, IO_IN, IO_OUT, RD_DATA;
  logic        REQ_READY, WR_READY, RD_VALID, DONE, BUSY, CLE, ALE, CHIP_SEL_N, WRITE_STROBE_N;
  logic        OUTPUT_STROBE_N, SPARE_AREA_GATE_N, WRITE_PROTECT_N, IO_OE_N, READY_BUSY_N;
  int          fail_count = 0, check_count = 0;
  logic [7:0]  got [$];
  nci_host dut (.*);
  nci_flash_model flash (.*);
  initial begin
    forever #25 CORE_CLK = ~CORE_CLK;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic give_verdict;
    if (fail_count == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : give_verdict
  task automatic run(input nci_op_t op, input logic [22:0] a, input int n, input logic sp, input logic [7:0] d0);
    int k, tail;
    logic wr;
    got.delete();
    k = 0;
    tail = 0;
    @(negedge CORE_CLK);
    REQ_OP = op;
    REQ_ADDR = a;
    REQ_LEN = 10'(n);
    REQ_SPARE = sp;
    WR_DATA = d0;
    WR_VALID = (op == OP_PROG);
    REQ_VALID = 1'b1;
    for (int t = 0; t < 4000 && tail < 6; t++) begin
      @(posedge CORE_CLK);
      wr = WR_VALID && WR_READY;
      if (RD_VALID && RD_READY) got.push_back(RD_DATA);
      if (DONE || tail > 0) tail++;
      @(negedge CORE_CLK);
      REQ_VALID = 1'b0;
      k += int'(wr);
      WR_DATA = d0 + 8'(k);
      WR_VALID = WR_VALID && k < n;
      RD_READY = ((t / 32) % 2 == 1) || tail > 0;
    end
    check(32'(tail), 32'd6);
    check({27'h000_0000, REQ_READY, BUSY, WRITE_PROTECT_N, CHIP_SEL_N, IO_OE_N}, 32'h0000_0017);
  endtask : run
  task automatic rd_cmp(input nci_op_t op, input logic [22:0] a, input int n, input logic sp, input logic [7:0] d0);
    run(op, a, n, sp, 8'h00);
    check(32'(got.size()), 32'(n));
    foreach (got[i]) check(32'(got[i]), 32'(d0 + (d0 == 8'hFF ? 8'h00 : 8'(i))));
  endtask : rd_cmp
  task automatic t_page;
    run(OP_PROG, {14'h0123, 1'b0, 8'h05}, 12, 1'b0, 8'h31);
    rd_cmp(OP_READ, {14'h0123, 1'b0, 8'h05}, 12, 1'b0, 8'h31);
    rd_cmp(OP_READ, {14'h0123, 1'b0, 8'h03}, 2, 1'b0, 8'hFF);
  endtask : t_page
  task automatic t_half;
    run(OP_PROG, {14'h0124, 1'b1, 8'h02}, 3, 1'b0, 8'hA0);
    rd_cmp(OP_READ, {14'h0124, 1'b1, 8'h02}, 3, 1'b0, 8'hA0);
    rd_cmp(OP_READ, {14'h0124, 1'b0, 8'h02}, 3, 1'b0, 8'hFF);
    rd_cmp(OP_READ, {14'h0123, 1'b0, 8'h00}, 4, 1'b1, 8'hFF);
  endtask : t_half
  task automatic t_erase;
    run(OP_ERASE, {14'h0123, 9'h000}, 1, 1'b0, 8'h00);
    rd_cmp(OP_READ, {14'h0123, 1'b0, 8'h05}, 12, 1'b0, 8'hFF);
    rd_cmp(OP_READ, {14'h0124, 1'b1, 8'h02}, 3, 1'b0, 8'hFF);
  endtask : t_erase
  task automatic t_misc;
    rd_cmp(OP_STATUS, 23'h0, 1, 1'b0, 8'hC0);
    rd_cmp(OP_READ_ID, 23'h0, 1, 1'b0, 8'h5A);
    run(OP_RESET, 23'h0, 1, 1'b0, 8'h00);
  endtask : t_misc
  initial begin
    repeat (6) @(negedge CORE_CLK);
    RST_N = 1'b1;
    @(negedge CORE_CLK);
    t_page();
    t_half();
    t_erase();
    t_misc();
    give_verdict();
  end
  initial begin
    #(50 * 60000);
    fail_count++;
    give_verdict();
  end
endmodule : nci_host_tb
`default_nettype wire
